// file: logic/gdio_defs.svh
// Constants of the general digital I/O port: register map, fields, reset values
// Assumes inclusion by bare name from the package and the design files
`ifndef GDIO_DEFS_SVH
`define GDIO_DEFS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define GDIO_PIN_COUNT      8
`define GDIO_ADDR_W         8
`define GDIO_DATA_W         32
`define GDIO_STRB_W         4
`define GDIO_BYTE_W         8

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define GDIO_OFS_OUTPUT     8'h00
`define GDIO_OFS_DIR        8'h04
`define GDIO_OFS_INPUT      8'h08
`define GDIO_OFS_CTRL       8'h0C

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define GDIO_CTRL_PUD_BIT   0
`define GDIO_RST_PUD        1'b0
`define GDIO_RST_BIT        1'b0
`define GDIO_RST_READY      1'b1

// ----------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------
`define GDIO_RESP_OKAY      2'h0
`define GDIO_RESP_SLVERR    2'h2

`endif

// file: logic/gdio_pkg.sv
// Types shared by the general digital I/O port modules
// Assumes gdio_defs.svh is on the include path
`include "gdio_defs.svh"

package gdio_pkg;
   typedef logic [`GDIO_ADDR_W-1:0] gdio_addr_t;
   typedef logic [`GDIO_DATA_W-1:0] gdio_word_t;
   typedef logic [`GDIO_STRB_W-1:0] gdio_strb_t;
   typedef logic [1:0]              gdio_resp_t;
endpackage : gdio_pkg

// file: logic/gdio_reg_if.sv
// Register access carrier between the AXI4-Lite front end and the port registers
// Assumes one clock; strobes are valid for one cycle, answers are combinational
interface gdio_reg_if;
   logic                 wr_en;
   gdio_pkg::gdio_addr_t wr_addr;
   gdio_pkg::gdio_word_t wr_data;
   gdio_pkg::gdio_strb_t wr_strb;
   logic                 wr_ok;
   gdio_pkg::gdio_addr_t rd_addr;
   gdio_pkg::gdio_word_t rd_data;
   logic                 rd_ok;

   modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 input  wr_ok, rd_data, rd_ok);
   modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 output wr_ok, rd_data, rd_ok);
endinterface : gdio_reg_if

// file: logic/gdio_axil_slave.sv
// AXI4-Lite slave front end of the port: one write and one read in flight
// Assumes the register side answers wr_ok, rd_data and rd_ok in the same cycle
`include "gdio_defs.svh"

module gdio_axil_slave (
   input  wire logic                 i_clk,
   input  wire logic                 i_reset_n,
   input  wire logic [31:0]          i_awaddr,
   input  wire logic                 i_awvalid,
   output      logic                 o_awready,
   input  wire logic [31:0]          i_wdata,
   input  wire gdio_pkg::gdio_strb_t i_wstrb,
   input  wire logic                 i_wvalid,
   output      logic                 o_wready,
   output      gdio_pkg::gdio_resp_t o_bresp,
   output      logic                 o_bvalid,
   input  wire logic                 i_bready,
   input  wire logic [31:0]          i_araddr,
   input  wire logic                 i_arvalid,
   output      logic                 o_arready,
   output      gdio_pkg::gdio_word_t o_rdata,
   output      gdio_pkg::gdio_resp_t o_rresp,
   output      logic                 o_rvalid,
   input  wire logic                 i_rready,
   gdio_reg_if.bus                   reg_if
);

   logic                 aw_held;
   logic                 w_held;
   logic                 ar_held;
   gdio_pkg::gdio_addr_t aw_addr;
   gdio_pkg::gdio_addr_t ar_addr;
   gdio_pkg::gdio_word_t w_data;
   gdio_pkg::gdio_strb_t w_strb;

   // ----------------------------------------------------------------------
   // Write channel: address and data accepted in either order
   // ----------------------------------------------------------------------
   assign reg_if.wr_en   = aw_held & w_held & ~o_bvalid;
   assign reg_if.wr_addr = aw_addr;
   assign reg_if.wr_data = w_data;
   assign reg_if.wr_strb = w_strb;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         aw_held   <= `GDIO_RST_BIT;
         aw_addr   <= '0;
         o_awready <= `GDIO_RST_READY;
      end else if (i_awvalid && o_awready) begin
         aw_held   <= 1'b1;
         aw_addr   <= i_awaddr[`GDIO_ADDR_W-1:0];
         o_awready <= 1'b0;
      end else if (reg_if.wr_en) begin
         aw_held   <= 1'b0;
      end else if (o_bvalid && i_bready) begin
         o_awready <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         w_held   <= `GDIO_RST_BIT;
         w_data   <= '0;
         w_strb   <= '0;
         o_wready <= `GDIO_RST_READY;
      end else if (i_wvalid && o_wready) begin
         w_held   <= 1'b1;
         w_data   <= i_wdata;
         w_strb   <= i_wstrb;
         o_wready <= 1'b0;
      end else if (reg_if.wr_en) begin
         w_held   <= 1'b0;
      end else if (o_bvalid && i_bready) begin
         o_wready <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_bvalid <= `GDIO_RST_BIT;
         o_bresp  <= `GDIO_RESP_OKAY;
      end else if (reg_if.wr_en) begin
         o_bvalid <= 1'b1;
         o_bresp  <= reg_if.wr_ok ? `GDIO_RESP_OKAY : `GDIO_RESP_SLVERR;
      end else if (i_bready) begin
         o_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Read channel: data sampled one cycle after the address is taken
   // ----------------------------------------------------------------------
   assign reg_if.rd_addr = ar_addr;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ar_held   <= `GDIO_RST_BIT;
         ar_addr   <= '0;
         o_arready <= `GDIO_RST_READY;
      end else if (i_arvalid && o_arready) begin
         ar_held   <= 1'b1;
         ar_addr   <= i_araddr[`GDIO_ADDR_W-1:0];
         o_arready <= 1'b0;
      end else if (ar_held) begin
         ar_held   <= 1'b0;
      end else if (o_rvalid && i_rready) begin
         o_arready <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rvalid <= `GDIO_RST_BIT;
         o_rdata  <= '0;
         o_rresp  <= `GDIO_RESP_OKAY;
      end else if (ar_held) begin
         o_rvalid <= 1'b1;
         o_rdata  <= reg_if.rd_data;
         o_rresp  <= reg_if.rd_ok ? `GDIO_RESP_OKAY : `GDIO_RESP_SLVERR;
      end else if (i_rready) begin
         o_rvalid <= 1'b0;
      end
   end

endmodule : gdio_axil_slave

// file: logic/gdio_pin_sync.sv
// Input synchroniser of the port: a level latch open while the clock is high,
// followed by the sample flip-flop on the next rising edge, one pair per pin
// Assumes the pad input is a plain digital level
module gdio_pin_sync #(
   parameter int PIN_COUNT = 8
) (
   input  wire logic                 i_clk,
   input  wire logic                 i_reset_n,
   input  wire logic [PIN_COUNT-1:0] i_pin,
   output      logic [PIN_COUNT-1:0] o_sample
);

   logic [PIN_COUNT-1:0] sync_latch;

   // ----------------------------------------------------------------------
   // Latch and sample stage per pin
   // ----------------------------------------------------------------------
   for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
      always_latch begin
         if (!i_reset_n) begin
            sync_latch[g] <= 1'b0;
         end else if (i_clk) begin
            sync_latch[g] <= i_pin[g];
         end
      end

      always_ff @(posedge i_clk or negedge i_reset_n) begin
         if (!i_reset_n) begin
            o_sample[g] <= 1'b0;
         end else begin
            o_sample[g] <= sync_latch[g];
         end
      end
   end

endmodule : gdio_pin_sync

// file: logic/gdio_port.sv
// General digital I/O port: output value, direction and input sample registers
// behind an AXI4-Lite slave, with pad drive, output enable and pull-up control.
// Assumes the pads resolve drive, pull-up and high impedance from the outputs.
//
// Function
// - Three separately addressed per-pin registers
// - Input sample read-only; others read/write
// - Writing one to input toggles output
// - Pull-up disable kills every pull-up
// - Direction one drives, zero releases
// - Pull-up only input, value one, enabled
// - Output drives value, pull-up off
// - Reset tri-states pins without clock
// - Input sample follows pin in any direction
// - Latch on clock high, load rising edge
// - Written value visible one period later
// - Per-pin writes leave other bits alone
// - Other pin functions leave port undisturbed
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`include "gdio_defs.svh"

module gdio_port #(
   parameter int PIN_COUNT = `GDIO_PIN_COUNT
) (
   input  wire logic                 I_REF_CLK,
   input  wire logic                 I_RESET_N,
   // AXI4-Lite slave
   input  wire logic [31:0]          I_S_AWADDR,
   input  wire logic                 I_S_AWVALID,
   output      logic                 O_S_AWREADY,
   input  wire logic [31:0]          I_S_WDATA,
   input  wire logic [3:0]           I_S_WSTRB,
   input  wire logic                 I_S_WVALID,
   output      logic                 O_S_WREADY,
   output      logic [1:0]           O_S_BRESP,
   output      logic                 O_S_BVALID,
   input  wire logic                 I_S_BREADY,
   input  wire logic [31:0]          I_S_ARADDR,
   input  wire logic                 I_S_ARVALID,
   output      logic                 O_S_ARREADY,
   output      logic [31:0]          O_S_RDATA,
   output      logic [1:0]           O_S_RRESP,
   output      logic                 O_S_RVALID,
   input  wire logic                 I_S_RREADY,
   // Pads
   input  wire logic [PIN_COUNT-1:0] I_PIN_IN,
   output      logic [PIN_COUNT-1:0] O_PIN_OUT,
   output      logic [PIN_COUNT-1:0] O_PIN_OE,
   output      logic [PIN_COUNT-1:0] O_PIN_PULLUP
);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   logic [PIN_COUNT-1:0] port_output_value_reg;
   logic [PIN_COUNT-1:0] port_direction_reg;
   logic [PIN_COUNT-1:0] port_input_sample_reg;
   logic                 global_pullup_disable;
   logic [PIN_COUNT-1:0] pin_pullup;

   logic [PIN_COUNT-1:0] next_output_value;
   logic [PIN_COUNT-1:0] next_direction;
   logic                 next_pullup_disable;

   logic [PIN_COUNT-1:0] wr_mask;
   logic [PIN_COUNT-1:0] wr_bits;
   logic                 wr_output;
   logic                 wr_dir;
   logic                 wr_input;
   logic                 wr_ctrl;

   gdio_reg_if reg_if ();

   // ----------------------------------------------------------------------
   // Bus front end
   // ----------------------------------------------------------------------
   gdio_axil_slave u_axil (
      .i_clk     (I_REF_CLK),
      .i_reset_n (I_RESET_N),
      .i_awaddr  (I_S_AWADDR),
      .i_awvalid (I_S_AWVALID),
      .o_awready (O_S_AWREADY),
      .i_wdata   (I_S_WDATA),
      .i_wstrb   (I_S_WSTRB),
      .i_wvalid  (I_S_WVALID),
      .o_wready  (O_S_WREADY),
      .o_bresp   (O_S_BRESP),
      .o_bvalid  (O_S_BVALID),
      .i_bready  (I_S_BREADY),
      .i_araddr  (I_S_ARADDR),
      .i_arvalid (I_S_ARVALID),
      .o_arready (O_S_ARREADY),
      .o_rdata   (O_S_RDATA),
      .o_rresp   (O_S_RRESP),
      .o_rvalid  (O_S_RVALID),
      .i_rready  (I_S_RREADY),
      .reg_if    (reg_if.bus)
   );

   // ----------------------------------------------------------------------
   // Input synchroniser
   // ----------------------------------------------------------------------
   // Sampled regardless of direction
   gdio_pin_sync #(
      .PIN_COUNT (PIN_COUNT)
   ) u_sync (
      .i_clk     (I_REF_CLK),
      .i_reset_n (I_RESET_N),
      .i_pin     (I_PIN_IN),
      .o_sample  (port_input_sample_reg)
   );

   // ----------------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------------
   // Separate register addresses
   assign wr_output = reg_if.wr_en && (reg_if.wr_addr == `GDIO_OFS_OUTPUT);
   assign wr_dir    = reg_if.wr_en && (reg_if.wr_addr == `GDIO_OFS_DIR);
   assign wr_input  = reg_if.wr_en && (reg_if.wr_addr == `GDIO_OFS_INPUT);
   assign wr_ctrl   = reg_if.wr_en && (reg_if.wr_addr == `GDIO_OFS_CTRL);

   assign reg_if.wr_ok = (reg_if.wr_addr == `GDIO_OFS_OUTPUT) || (reg_if.wr_addr == `GDIO_OFS_DIR)
                      || (reg_if.wr_addr == `GDIO_OFS_INPUT)  || (reg_if.wr_addr == `GDIO_OFS_CTRL);

   // Byte strobes gate each pin so a partial write touches only its lanes
   for (genvar g = 0; g < PIN_COUNT; g++) begin : g_mask
      assign wr_mask[g] = reg_if.wr_strb[g / `GDIO_BYTE_W];
      assign wr_bits[g] = reg_if.wr_data[g] & wr_mask[g];
   end

   // ----------------------------------------------------------------------
   // Next register values
   // ----------------------------------------------------------------------
   always_comb begin
      next_output_value = port_output_value_reg;
      if (wr_output) begin
         next_output_value = (port_output_value_reg & ~wr_mask) | wr_bits;
      end else if (wr_input) begin
         next_output_value = port_output_value_reg ^ wr_bits;
      end
   end

   always_comb begin
      next_direction = port_direction_reg;
      if (wr_dir) begin
         next_direction = (port_direction_reg & ~wr_mask) | wr_bits;
      end
   end

   always_comb begin
      next_pullup_disable = global_pullup_disable;
      if (wr_ctrl && reg_if.wr_strb[0]) begin
         next_pullup_disable = reg_if.wr_data[`GDIO_CTRL_PUD_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   // Async clear, no clock needed
   always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         port_output_value_reg <= '0;
      end else begin
         port_output_value_reg <= next_output_value;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         port_direction_reg <= '0;
      end else begin
         port_direction_reg <= next_direction;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         global_pullup_disable <= `GDIO_RST_PUD;
      end else begin
         global_pullup_disable <= next_pullup_disable;
      end
   end

   // Pull-up is built from next values so it moves in the same edge as the
   // driver enable; a one-cycle overlap of driver and pull-up is avoided
   always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         pin_pullup <= '0;
      end else begin
         // Input, value one, enabled; global disable; off when driving
         pin_pullup <= ~next_direction & next_output_value & {PIN_COUNT{~next_pullup_disable}};
      end
   end

   // ----------------------------------------------------------------------
   // Pad drive
   // ----------------------------------------------------------------------
   // Direction enables driver
   assign O_PIN_OE     = port_direction_reg;
   assign O_PIN_OUT    = port_output_value_reg;
   assign O_PIN_PULLUP = pin_pullup;

   // ----------------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------------
   always_comb begin
      reg_if.rd_data = '0;
      reg_if.rd_ok   = 1'b1;
      unique case (reg_if.rd_addr)
         `GDIO_OFS_OUTPUT: begin
            reg_if.rd_data[PIN_COUNT-1:0] = port_output_value_reg;
         end
         `GDIO_OFS_DIR: begin
            reg_if.rd_data[PIN_COUNT-1:0] = port_direction_reg;
         end
         `GDIO_OFS_INPUT: begin
            reg_if.rd_data[PIN_COUNT-1:0] = port_input_sample_reg;
         end
         `GDIO_OFS_CTRL: begin
            reg_if.rd_data[`GDIO_CTRL_PUD_BIT] = global_pullup_disable;
         end
         default: begin
            reg_if.rd_ok = 1'b0;
         end
      endcase
   end

   // Alternate functions sit outside; no pin shares state with another
   // Pad echo reaches the sample one period after the register edge

endmodule : gdio_port

// file: verification/gdio_port_props.sv
// Checker of the digital I/O port, bound to the top module by the testbench
// Assumes one clock domain and sees only the top module's ports
module gdio_port_props #(
   parameter int PIN_COUNT = 8
) (
   input wire logic                 I_REF_CLK,
   input wire logic                 I_RESET_N,
   input wire logic                 I_S_AWVALID,
   input wire logic                 O_S_AWREADY,
   input wire logic                 I_S_WVALID,
   input wire logic                 O_S_WREADY,
   input wire logic                 O_S_BVALID,
   input wire logic                 I_S_BREADY,
   input wire logic                 I_S_ARVALID,
   input wire logic                 O_S_ARREADY,
   input wire logic [31:0]          O_S_RDATA,
   input wire logic                 O_S_RVALID,
   input wire logic                 I_S_RREADY,
   input wire logic [PIN_COUNT-1:0] O_PIN_OUT,
   input wire logic [PIN_COUNT-1:0] O_PIN_OE,
   input wire logic [PIN_COUNT-1:0] O_PIN_PULLUP
);
   default clocking cb @(posedge I_REF_CLK);
   endclocking
   default disable iff (!I_RESET_N);

   // ----------------------------------------------------------------------
   // Pads
   // ----------------------------------------------------------------------
   // Reset must be watched while it is active, so no disable here
   property p_reset_off;
      disable iff (1'h0) !I_RESET_N |-> (O_PIN_OE == '0) && (O_PIN_PULLUP == '0);
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("pads not released in reset");
   property p_pu_not_out;
      (O_PIN_PULLUP & O_PIN_OE) == '0;
   endproperty
   a_pu_not_out: assert property (p_pu_not_out) else $error("pull-up on a driven pin");
   property p_pu_needs_one;
      (O_PIN_PULLUP & ~O_PIN_OUT) == '0;
   endproperty
   a_pu_needs_one: assert property (p_pu_needs_one) else $error("pull-up with value zero");
   property p_oe_moves;
      !$stable(O_PIN_OE) |-> $rose(O_S_BVALID);
   endproperty
   a_oe_moves: assert property (p_oe_moves) else $error("enable moved without a write");
   property p_out_moves;
      !$stable(O_PIN_OUT) |-> $rose(O_S_BVALID);
   endproperty
   a_out_moves: assert property (p_out_moves) else $error("drive moved without a write");

   // ----------------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------------
   property p_wr_answer;
      I_S_AWVALID && O_S_AWREADY && I_S_WVALID && O_S_WREADY |=> !O_S_BVALID ##1 O_S_BVALID;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer off time");
   property p_rd_answer;
      I_S_ARVALID && O_S_ARREADY |=> !O_S_ARREADY ##1 O_S_RVALID;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer off time");
   property p_r_hold;
      O_S_RVALID && !I_S_RREADY |=> O_S_RVALID && $stable(O_S_RDATA);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data not held");
   property p_upper_zero;
      O_S_RVALID |-> (O_S_RDATA >> PIN_COUNT) == 32'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("bits above the pins set");

   c_write: cover property (I_S_AWVALID && O_S_AWREADY && I_S_WVALID && O_S_WREADY);
   c_read: cover property (I_S_ARVALID && O_S_ARREADY);
   c_pullup: cover property (O_PIN_PULLUP != '0);
endmodule : gdio_port_props

// file: verification/gdio_pad_model.sv
// Board model facing the port pads: resolves driver, pull-up and board sources
// Assumes the testbench chooses which pins the board drives
module gdio_pad_model #(
   parameter int PIN_COUNT = 8
) (
   input  wire logic                 i_clk,
   input  wire logic [PIN_COUNT-1:0] i_out,
   input  wire logic [PIN_COUNT-1:0] i_oe,
   input  wire logic [PIN_COUNT-1:0] i_pullup,
   input  wire logic [PIN_COUNT-1:0] i_ext_en,
   input  wire logic [PIN_COUNT-1:0] i_ext_val,
   output      logic [PIN_COUNT-1:0] o_pin
);
   logic [PIN_COUNT-1:0] flt = '0;
   // Undriven pads wander so a stale level never passes
   always @(posedge i_clk) flt <= ~flt;
   // Driver wins, then the board, then the pull-up
   assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val)
                | (~i_oe & ~i_ext_en & i_pullup) | (~i_oe & ~i_ext_en & ~i_pullup & flt);
endmodule : gdio_pad_model

// file: verification/tb_top.sv
// Testbench of the digital I/O port: AXI4-Lite tasks, board model, bound checker
// Assumes the design, checker and board model files are compiled first
`include "gdio_defs.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int          PINS   = 6;
   localparam logic [31:0] A_OUT  = {24'h000000, `GDIO_OFS_OUTPUT};
   localparam logic [31:0] A_DIR  = {24'h000000, `GDIO_OFS_DIR};
   localparam logic [31:0] A_IN   = {24'h000000, `GDIO_OFS_INPUT};
   localparam logic [31:0] A_CTRL = {24'h000000, `GDIO_OFS_CTRL};
   localparam logic [1:0]  OK     = `GDIO_RESP_OKAY;
   localparam logic [1:0]  ERR    = `GDIO_RESP_SLVERR;
   logic            ref_clk = 1'h0, clk_run = 1'h1, reset_n = 1'h1;
   logic [31:0]     awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
   logic [3:0]      wstrb = 4'h0;
   logic            awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic            awready, wready, bvalid, arready, rvalid;
   logic [1:0]      bresp, rresp;
   logic [PINS-1:0] pin_in, pin_out, pin_oe, pin_pu;
   logic [PINS-1:0] ext_en = 6'h00, ext_val = 6'h00;
   logic [31:0]     exp_out = 32'h0, exp_dir = 32'h0;
   logic            exp_pud = 1'h0;
   int              n_fail = 0, n_tests = 0, cycles = 0;
   logic [31:0]     regs [3] = '{A_OUT, A_DIR, A_CTRL};

   // Clock can stop to show reset acting without it
   always #25 ref_clk = ~ref_clk & clk_run;

   gdio_port #(.PIN_COUNT(PINS)) dut_u (
      .I_REF_CLK(ref_clk), .I_RESET_N(reset_n),
      .I_S_AWADDR(awaddr), .I_S_AWVALID(awvalid), .O_S_AWREADY(awready),
      .I_S_WDATA(wdata), .I_S_WSTRB(wstrb), .I_S_WVALID(wvalid), .O_S_WREADY(wready),
      .O_S_BRESP(bresp), .O_S_BVALID(bvalid), .I_S_BREADY(bready),
      .I_S_ARADDR(araddr), .I_S_ARVALID(arvalid), .O_S_ARREADY(arready),
      .O_S_RDATA(rdata), .O_S_RRESP(rresp), .O_S_RVALID(rvalid), .I_S_RREADY(rready),
      .I_PIN_IN(pin_in), .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe), .O_PIN_PULLUP(pin_pu));

   gdio_pad_model #(.PIN_COUNT(PINS)) pads_u (.i_clk(ref_clk), .i_out(pin_out), .i_oe(pin_oe),
      .i_pullup(pin_pu), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin(pin_in));

   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                         input logic [1:0] er);
      bit done;
      done = 1'h0;
      @(posedge ref_clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      while (!done) begin
         @(posedge ref_clk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid) begin
            cmp("write response", 32'(er), 32'(bresp));
            bready <= 1'h0;
            done = 1'h1;
         end
      end
   endtask : axi_wr

   task automatic axi_rd(input logic [31:0] a, input logic [1:0] er, output logic [31:0] d);
      bit done;
      done = 1'h0;
      d = 32'h0;
      @(posedge ref_clk);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      while (!done) begin
         @(posedge ref_clk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid) begin
            d = rdata;
            cmp("read response", 32'(er), 32'(rresp));
            rready <= 1'h0;
            done = 1'h1;
         end
      end
   endtask : axi_rd

   // Expected pad levels at the input sampler
   function automatic logic [31:0] exp_in();
      logic [PINS-1:0] d, pu;
      d  = exp_dir[PINS-1:0];
      pu = ~d & exp_out[PINS-1:0] & {PINS{~exp_pud}};
      return 32'((d & exp_out[PINS-1:0]) | (~d & ext_en & ext_val) | (~d & ~ext_en & pu));
   endfunction : exp_in

   task automatic check_pads();
      logic [PINS-1:0] pu;
      pu = ~exp_dir[PINS-1:0] & exp_out[PINS-1:0] & {PINS{~exp_pud}};
      cmp("pad enable", exp_dir, 32'(pin_oe));
      cmp("pad drive", exp_out, 32'(pin_out));
      cmp("pad pull-up", 32'(pu), 32'(pin_pu));
   endtask : check_pads

   task automatic check_zero();
      logic [31:0] d;
      for (int k = 0; k < 3; k++) begin
         axi_rd(regs[k], OK, d);
         cmp("reset value", 32'h0, d);
      end
   endtask : check_zero

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test

   // A hang costs a mismatch; the run needs about a hundred cycles
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         n_fail++;
         stop_test();
      end
   end

   // ----------------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------------
   initial begin
      logic [31:0] rd;
      reset_n <= 1'h0;
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'h1;
      check_pads();
      check_zero();
      $display("test reset values done");
      ext_en  <= 6'h3A;
      ext_val <= 6'h28;
      exp_out = 32'h05;
      axi_wr(A_OUT, 32'h05, 4'hF, OK);
      check_pads();
      axi_rd(A_IN, OK, rd);
      cmp("input sample", exp_in(), rd);
      $display("test pull-up input done");
      exp_pud = 1'h1;
      axi_wr(A_CTRL, 32'h01, 4'hF, OK);
      check_pads();
      axi_rd(A_CTRL, OK, rd);
      cmp("control reg", 32'h01, rd);
      exp_pud = 1'h0;
      axi_wr(A_CTRL, 32'h00, 4'hF, OK);
      check_pads();
      $display("test pull-up disable done");
      ext_en <= 6'h38;
      exp_dir = 32'h03;
      // Pin 0 pull-up to high, pin 1 tri-state to low
      axi_wr(A_DIR, 32'h03, 4'hF, OK);
      check_pads();
      axi_rd(A_IN, OK, rd);
      cmp("driven read-back", exp_in(), rd);
      $display("test output drive done");
      exp_out = exp_out ^ 32'h12;
      axi_wr(A_IN, 32'h12, 4'hF, OK);
      check_pads();
      axi_wr(A_IN, 32'h00, 4'hF, OK);
      axi_rd(A_OUT, OK, rd);
      cmp("toggled output", exp_out, rd);
      axi_rd(A_IN, OK, rd);
      cmp("input after toggle", exp_in(), rd);
      $display("test toggle done");
      axi_wr(A_OUT, 32'hFFFFFFFF, 4'hE, OK);
      exp_dir = 32'h07;
      axi_wr(A_DIR, 32'hFFFFFF07, 4'hF, OK);
      axi_rd(A_DIR, OK, rd);
      cmp("direction reg", exp_dir, rd);
      axi_rd(A_OUT, OK, rd);
      cmp("unstrobed output", exp_out, rd);
      check_pads();
      $display("test strobes and width done");
      axi_wr(32'h00000010, 32'h0000003F, 4'hF, ERR);
      axi_rd(32'h00000010, ERR, rd);
      cmp("unmapped read", 32'h0, rd);
      check_pads();
      $display("test unmapped done");
      clk_run <= 1'h0;
      #100;
      reset_n <= 1'h0;
      #10;
      exp_out = 32'h0;
      exp_dir = 32'h0;
      check_pads();
      #40;
      clk_run = 1'h1;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'h1;
      check_zero();
      $display("test clockless reset done");
      stop_test();
   end
endmodule : tb_top
bind gdio_port gdio_port_props #(.PIN_COUNT(PIN_COUNT)) props_u (
   .I_REF_CLK, .I_RESET_N, .I_S_AWVALID, .O_S_AWREADY, .I_S_WVALID, .O_S_WREADY,
   .O_S_BVALID, .I_S_BREADY, .I_S_ARVALID, .O_S_ARREADY, .O_S_RDATA, .O_S_RVALID,
   .I_S_RREADY, .O_PIN_OUT, .O_PIN_OE, .O_PIN_PULLUP);
